//--- quasi_bidir_port_logic.sv
// How it works
// - four ports, latch driver input per bit
// - port zero multiplexes low address and data
// - port two drives high address when wide
// - select switches drivers from latch to bus
// - port three carries serial, interrupt, timer, strobes
// - port one bits 0,1 serve timer c
// - zero latch forces pin low, except port two in wide address
// - latch one lets alternate output drive
// - write loads latch, reads pick latch/pin
// - external access: port zero latch set ones
// - port zero open drain except address/data ones
// - reset sets every latch bit to one
// - latch updates at state six phase two
// - driver samples latch in phase one
// - rising latch bit on ports one to three gets strong pull-up
// - strong pulse two periods, keeper latched
// - port two strong while emitting address ones
// - read-modify-write reads the latch
// - bit rmw writes whole byte back
// - narrow address keeps port two latch shown
`timescale 1ns/10ps
`default_nettype none
module quasi_bidir_port_logic (
  input  wire logic                           core_clk_i,
  input  wire logic                           rstn_i,
  // cpu timing
  input  wire logic [2:0]                     state_num_i,
  input  wire logic                           phase_i,
  // cpu port access
  input  wire logic [1:0]                     port_sel_i,
  input  wire logic                           write_latch_i,
  input  wire logic                           read_latch_i,
  input  wire logic                           read_pin_i,
  input  wire logic [qb_port_pkg::PORT_W-1:0] bus_wdata_i,
  output logic      [qb_port_pkg::PORT_W-1:0] bus_rdata_o,
  output logic                                bus_rvalid_o,
  // external memory
  input  wire logic                           ext_access_i,
  input  wire logic                           ext_addr_phase_i,
  input  wire logic                           ext_wide_addr_i,
  input  wire logic                           ext_data_drive_i,
  input  wire logic [qb_port_pkg::PORT_W-1:0] ext_addr_lo_i,
  input  wire logic [qb_port_pkg::PORT_W-1:0] ext_addr_hi_i,
  input  wire logic [qb_port_pkg::PORT_W-1:0] ext_wdata_i,
  output logic      [qb_port_pkg::PORT_W-1:0] ext_rdata_o,
  // alternate outputs
  input  wire logic                           serial_tx_i,
  input  wire logic                           data_write_strobe_n_i,
  input  wire logic                           data_read_strobe_n_i,
  // alternate inputs
  output logic                                serial_rx_o,
  output logic                                ext_interrupt_a_o,
  output logic                                ext_interrupt_b_o,
  output logic                                timer_a_count_in_o,
  output logic                                timer_b_count_in_o,
  output logic                                timer_c_count_in_o,
  output logic                                timer_c_capture_trigger_o,
  // pins
  input  wire logic [qb_port_pkg::PORT_W-1:0] port_zero_pin_i,
  input  wire logic [qb_port_pkg::PORT_W-1:0] port_one_pin_i,
  input  wire logic [qb_port_pkg::PORT_W-1:0] port_two_pin_i,
  input  wire logic [qb_port_pkg::PORT_W-1:0] port_three_pin_i,
  output logic      [qb_port_pkg::PORT_W-1:0] port_zero_pulldown_o,
  output logic      [qb_port_pkg::PORT_W-1:0] port_zero_pullup_o,
  output logic      [qb_port_pkg::PORT_W-1:0] port_one_pulldown_o,
  output logic      [qb_port_pkg::PORT_W-1:0] port_two_pulldown_o,
  output logic      [qb_port_pkg::PORT_W-1:0] port_three_pulldown_o,
  output logic      [qb_port_pkg::PORT_W-1:0] port_one_strong_o,
  output logic      [qb_port_pkg::PORT_W-1:0] port_two_strong_o,
  output logic      [qb_port_pkg::PORT_W-1:0] port_three_strong_o,
  output logic      [qb_port_pkg::PORT_W-1:0] port_one_keeper_o,
  output logic      [qb_port_pkg::PORT_W-1:0] port_two_keeper_o,
  output logic      [qb_port_pkg::PORT_W-1:0] port_three_keeper_o
);
  import qb_port_pkg::*;

  // ************************************************************
  // declarations
  // ************************************************************
  logic [PORT_W-1:0] port_zero_latch;
  logic [PORT_W-1:0] port_one_latch;
  logic [PORT_W-1:0] port_two_latch;
  logic [PORT_W-1:0] port_three_latch;
  logic [PORT_W-1:0] pin_sync [NUM_PORTS];
  logic [PORT_W-1:0] drv_held [NUM_PORTS];
  logic [PORT_W-1:0] drv_prev [NUM_PORTS];
  logic [PORT_W-1:0] rise     [NUM_PORTS];
  logic [1:0]        boost_cnt [1:NUM_PORTS-1][PORT_W];
  logic [PORT_W-1:0] keeper   [1:NUM_PORTS-1];
  logic [PORT_W-1:0] alt_out;
  logic [PORT_W-1:0] p0_level;
  logic [PORT_W-1:0] p2_level;
  logic              state_six_phase_two;
  logic              state_one_phase_one;
  logic              state_one_phase_two;
  logic              p2_addr_mode;
  read_sel_t         read_sel;
  logic [PORT_W-1:0] next_rdata;

  // pick one byte of four by port number
  function automatic logic [PORT_W-1:0] pick_port(
    input logic [1:0]        sel,
    input logic [PORT_W-1:0] b0,
    input logic [PORT_W-1:0] b1,
    input logic [PORT_W-1:0] b2,
    input logic [PORT_W-1:0] b3
  );
    logic [PORT_W-1:0] r;
    r = b0;
    if (sel == PORT_ONE) begin
      r = b1;
    end else if (sel == PORT_TWO) begin
      r = b2;
    end else if (sel == PORT_THREE) begin
      r = b3;
    end
    return r;
  endfunction

  // ************************************************************
  // timing and input synchronisers
  // ************************************************************
  assign state_six_phase_two = (state_num_i == STATE_SIX)
                               && (phase_i == PHASE_TWO);
  assign state_one_phase_one = (state_num_i == STATE_ONE)
                               && (phase_i == PHASE_ONE);
  assign state_one_phase_two = (state_num_i == STATE_ONE)
                               && (phase_i == PHASE_TWO);

  pin_sync u_sync_p0 (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .async_i    (port_zero_pin_i),
    .sync_o     (pin_sync[0])
  );
  pin_sync u_sync_p1 (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .async_i    (port_one_pin_i),
    .sync_o     (pin_sync[1])
  );
  pin_sync u_sync_p2 (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .async_i    (port_two_pin_i),
    .sync_o     (pin_sync[2])
  );
  pin_sync u_sync_p3 (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .async_i    (port_three_pin_i),
    .sync_o     (pin_sync[3])
  );

  // ************************************************************
  // port latches
  // ************************************************************
  // write taken only at state six phase two; rmw data already merged
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      port_zero_latch  <= LATCH_RESET;
      port_one_latch   <= LATCH_RESET;
      port_two_latch   <= LATCH_RESET;
      port_three_latch <= LATCH_RESET;
    end else begin
      if (ext_access_i) begin
        port_zero_latch <= ALL_ONES;
      end else if (write_latch_i && state_six_phase_two
                   && port_sel_i == PORT_ZERO) begin
        port_zero_latch <= bus_wdata_i;
      end
      if (write_latch_i && state_six_phase_two) begin
        if (port_sel_i == PORT_ONE) begin
          port_one_latch <= bus_wdata_i;
        end else if (port_sel_i == PORT_TWO) begin
          port_two_latch <= bus_wdata_i;
        end else if (port_sel_i == PORT_THREE) begin
          port_three_latch <= bus_wdata_i;
        end
      end
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  always_comb begin
    read_sel = RD_NONE;
    if (read_latch_i) begin
      read_sel = RD_LATCH;
    end else if (read_pin_i) begin
      read_sel = RD_PIN;
    end
  end

  always_comb begin
    next_rdata = ALL_ZERO;
    case (read_sel)
      RD_LATCH: next_rdata = pick_port(port_sel_i, port_zero_latch,
                  port_one_latch, port_two_latch, port_three_latch);
      RD_PIN:   next_rdata = pick_port(port_sel_i, pin_sync[0],
                  pin_sync[1], pin_sync[2], pin_sync[3]);
      default:  next_rdata = ALL_ZERO;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      bus_rdata_o  <= ALL_ZERO;
      bus_rvalid_o <= 1'b0;
      ext_rdata_o  <= ALL_ZERO;
    end else begin
      bus_rdata_o  <= next_rdata;
      bus_rvalid_o <= read_sel != RD_NONE;
      ext_rdata_o  <= pin_sync[0];
    end
  end

  // ************************************************************
  // alternate functions
  // ************************************************************
  always_comb begin
    alt_out = ALL_ONES;
    alt_out[P3_TX_BIT] = serial_tx_i;
    alt_out[P3_WR_BIT] = data_write_strobe_n_i;
    alt_out[P3_RD_BIT] = data_read_strobe_n_i;
  end

  // live synchronised level always feeds alternate inputs
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      serial_rx_o               <= 1'b1;
      ext_interrupt_a_o         <= 1'b1;
      ext_interrupt_b_o         <= 1'b1;
      timer_a_count_in_o        <= 1'b1;
      timer_b_count_in_o        <= 1'b1;
      timer_c_count_in_o        <= 1'b1;
      timer_c_capture_trigger_o <= 1'b1;
    end else begin
      serial_rx_o        <= pin_sync[3][P3_RX_BIT];
      ext_interrupt_a_o  <= pin_sync[3][P3_INTA_BIT];
      ext_interrupt_b_o  <= pin_sync[3][P3_INTB_BIT];
      timer_a_count_in_o <= pin_sync[3][P3_TMRA_BIT];
      timer_b_count_in_o <= pin_sync[3][P3_TMRB_BIT];
      timer_c_count_in_o <= HAS_TIMER_C
                            & pin_sync[1][P1_TMRC_BIT];
      timer_c_capture_trigger_o <= HAS_TIMER_C
                            & pin_sync[1][P1_CAPT_BIT];
    end
  end

  // ************************************************************
  // output drivers
  // ************************************************************
  // buffers follow the latch only in phase one, hold through phase two
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      drv_held[0] <= LATCH_RESET;
      drv_held[1] <= LATCH_RESET;
      drv_held[2] <= LATCH_RESET;
      drv_held[3] <= LATCH_RESET;
    end else if (phase_i == PHASE_ONE) begin
      drv_held[0] <= port_zero_latch;
      drv_held[1] <= port_one_latch;
      drv_held[2] <= port_two_latch;
      // alternate output passes only where latch holds one
      drv_held[3] <= port_three_latch & alt_out;
    end
  end

  assign p2_addr_mode = ext_access_i && ext_wide_addr_i;
  // narrow address leaves the latch on port two
  assign p2_level = p2_addr_mode ? ext_addr_hi_i : drv_held[2];
  assign p0_level = ext_addr_phase_i ? ext_addr_lo_i : ext_wdata_i;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      port_zero_pulldown_o  <= ALL_ZERO;
      port_zero_pullup_o    <= ALL_ZERO;
      port_one_pulldown_o   <= ALL_ZERO;
      port_two_pulldown_o   <= ALL_ZERO;
      port_three_pulldown_o <= ALL_ZERO;
    end else begin
      // one in latch turns the low driver off so pins can be inputs
      port_one_pulldown_o   <= ~drv_held[1];
      port_two_pulldown_o   <= ~p2_level;
      port_three_pulldown_o <= ~drv_held[3];
      if (ext_access_i && (ext_addr_phase_i || ext_data_drive_i)) begin
        port_zero_pulldown_o <= ~p0_level;
        port_zero_pullup_o   <= p0_level;
      end else if (ext_access_i) begin
        port_zero_pulldown_o <= ALL_ZERO;
        port_zero_pullup_o   <= ALL_ZERO;
      end else begin
        // open drain: a latched one floats the pin
        port_zero_pulldown_o <= ~drv_held[0];
        port_zero_pullup_o   <= ALL_ZERO;
      end
    end
  end

  // ************************************************************
  // strong pull-up and keeper, ports one to three
  // ************************************************************
  always_comb begin
    rise[0] = ALL_ZERO;
    rise[1] = drv_held[1] & ~drv_prev[1];
    rise[2] = drv_held[2] & ~drv_prev[2];
    rise[3] = drv_held[3] & ~drv_prev[3];
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      drv_prev[0] <= LATCH_RESET;
      drv_prev[1] <= LATCH_RESET;
      drv_prev[2] <= LATCH_RESET;
      drv_prev[3] <= LATCH_RESET;
    end else begin
      drv_prev <= drv_held;
    end
  end

  genvar gp, gb;
  generate
    for (gp = 1; gp < NUM_PORTS; gp++) begin : g_port
      for (gb = 0; gb < PORT_W; gb++) begin : g_bit
        // pulse starts with the rising driver in state one, either phase
        always_ff @(posedge core_clk_i) begin
          if (!rstn_i) begin
            boost_cnt[gp][gb] <= 2'h0;
            keeper[gp][gb]    <= 1'b1;
          end else begin
            if (rise[gp][gb] && (state_one_phase_one
                                 || state_one_phase_two)) begin
              boost_cnt[gp][gb] <= BOOST_CYCLES;
            end else if (boost_cnt[gp][gb] != 2'h0) begin
              boost_cnt[gp][gb] <= boost_cnt[gp][gb] - 2'h1;
            end
            if (boost_cnt[gp][gb] != 2'h0) begin
              keeper[gp][gb] <= 1'b1;
            end else if (gp == 2 && p2_addr_mode) begin
              keeper[gp][gb] <= p2_level[gb];
            end else if (!drv_held[gp][gb] || !pin_sync[gp][gb]) begin
              // a low pin drops the keeper until the next boost or, on port two, a one emitted in wide address mode
              keeper[gp][gb] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      port_one_strong_o   <= ALL_ZERO;
      port_two_strong_o   <= ALL_ZERO;
      port_three_strong_o <= ALL_ZERO;
      port_one_keeper_o   <= ALL_ONES;
      port_two_keeper_o   <= ALL_ONES;
      port_three_keeper_o <= ALL_ONES;
    end else begin
      for (int b = 0; b < PORT_W; b++) begin
        port_one_strong_o[b]   <= boost_cnt[1][b] != 2'h0;
        port_three_strong_o[b] <= boost_cnt[3][b] != 2'h0;
        port_two_strong_o[b]   <= (boost_cnt[2][b] != 2'h0)
                                  || (p2_addr_mode && p2_level[b]);
      end
      port_one_keeper_o   <= keeper[1];
      port_two_keeper_o   <= keeper[2];
      port_three_keeper_o <= keeper[3];
    end
  end
endmodule
`default_nettype wire

//--- qb_port_pkg.sv
package qb_port_pkg;
  localparam int          PORT_W      = 8;
  localparam int          NUM_PORTS   = 4;
  localparam logic [1:0]  PORT_ZERO   = 2'h0;
  localparam logic [1:0]  PORT_ONE    = 2'h1;
  localparam logic [1:0]  PORT_TWO    = 2'h2;
  localparam logic [1:0]  PORT_THREE  = 2'h3;
  localparam logic [7:0]  LATCH_RESET = 8'hFF;
  localparam logic [7:0]  ALL_ZERO    = 8'h00;
  localparam logic [7:0]  ALL_ONES    = 8'hFF;
  // machine cycle timing: 6 states of 2 phases, one phase per core clock
  localparam logic [2:0]  STATE_ONE   = 3'h1;
  localparam logic [2:0]  STATE_SIX   = 3'h6;
  localparam logic        PHASE_ONE   = 1'b0;
  localparam logic        PHASE_TWO   = 1'b1;
  // strong pull-up pulse in oscillator periods, one period per core clock
  localparam int          BOOST_OSC_PERIODS = 2;
  localparam logic [1:0]  BOOST_CYCLES = 2'(BOOST_OSC_PERIODS);
  // port three and port one alternate function bit positions
  localparam int          P3_RX_BIT   = 0;
  localparam int          P3_TX_BIT   = 1;
  localparam int          P3_INTA_BIT = 2;
  localparam int          P3_INTB_BIT = 3;
  localparam int          P3_TMRA_BIT = 4;
  localparam int          P3_TMRB_BIT = 5;
  localparam int          P3_WR_BIT   = 6;
  localparam int          P3_RD_BIT   = 7;
  localparam int          P1_TMRC_BIT = 0;
  localparam int          P1_CAPT_BIT = 1;
  localparam logic        HAS_TIMER_C = 1'b1;
  typedef enum logic [1:0] {
    RD_NONE,
    RD_LATCH,
    RD_PIN
  } read_sel_t;
endpackage

//--- pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  input  wire logic                           core_clk_i,
  input  wire logic                           rstn_i,
  input  wire logic [qb_port_pkg::PORT_W-1:0] async_i,
  output logic      [qb_port_pkg::PORT_W-1:0] sync_o
);
  import qb_port_pkg::*;

  logic [PORT_W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      meta   <= ALL_ONES;
      sync_o <= ALL_ONES;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule
`default_nettype wire

//--- quasi_bidir_port_logic_props.sv
`timescale 1ns/10ps
`default_nettype none
module quasi_bidir_port_logic_props (
  input wire logic       core_clk_i,
  input wire logic       rstn_i,
  input wire logic [2:0] state_num_i,
  input wire logic       phase_i,
  input wire logic [1:0] port_sel_i,
  input wire logic       write_latch_i,
  input wire logic       read_latch_i,
  input wire logic       read_pin_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic       bus_rvalid_o,
  input wire logic       ext_access_i,
  input wire logic [7:0] port_three_pin_i,
  input wire logic       timer_a_count_in_o,
  input wire logic [7:0] port_zero_pulldown_o,
  input wire logic [7:0] port_zero_pullup_o,
  input wire logic [7:0] port_one_pulldown_o,
  input wire logic [7:0] port_two_pulldown_o,
  input wire logic [7:0] port_three_pulldown_o,
  input wire logic [7:0] port_one_strong_o,
  input wire logic [7:0] port_one_keeper_o
);
  import qb_port_pkg::*;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  // ****************************************
  // driver, read and alternate input checks
  // ****************************************
  // 4 cycles covers latch load plus the phase one sample of the driver
  AST_P1_WRITE: assert property (
    write_latch_i && port_sel_i == PORT_ONE && state_num_i == STATE_SIX
    && phase_i == PHASE_TWO
    |-> ##4 port_one_pulldown_o == ~$past(bus_wdata_i, 4))
    else $error("port one driver does not follow written byte");
  AST_RESET_LEVELS: assert property (
    $rose(rstn_i) |-> (port_zero_pulldown_o | port_one_pulldown_o
    | port_two_pulldown_o | port_three_pulldown_o | port_zero_pullup_o)
    == ALL_ZERO)
    else $error("a driver is on right after reset");
  AST_STRONG_TWO: assert property (
    $rose(port_one_strong_o[1])
    |=> port_one_strong_o[1] ##1 !port_one_strong_o[1])
    else $error("strong pull-up pulse is not two cycles");
  AST_KEEPER_SET: assert property (
    $fell(port_one_strong_o[1]) |-> port_one_keeper_o[1])
    else $error("keeper not latched on by the strong pulse");
  AST_STRONG_NOT_LOW: assert property (
    (port_one_strong_o & port_one_pulldown_o) == ALL_ZERO)
    else $error("strong pull-up fights the low driver");
  AST_P0_NO_CLASH: assert property (
    (port_zero_pullup_o & port_zero_pulldown_o) == ALL_ZERO)
    else $error("port zero drives both ways");
  AST_P0_OPEN_DRAIN: assert property (
    !ext_access_i && !$past(ext_access_i) && !$past(ext_access_i, 2)
    |-> port_zero_pullup_o == ALL_ZERO)
    else $error("port zero high driver on outside external access");
  AST_READ_ANSWER: assert property (
    bus_rvalid_o == $past(read_latch_i || read_pin_i))
    else $error("read answer not one cycle after strobe");
  // tolerant of one extra register stage after the synchroniser
  AST_ALT_INPUT: assert property (
    $past(port_three_pin_i[4], 2) == $past(port_three_pin_i[4], 3)
    |-> timer_a_count_in_o == $past(port_three_pin_i[4], 2))
    else $error("timer a input does not follow its pin");
endmodule
bind quasi_bidir_port_logic quasi_bidir_port_logic_props props_inst (.*);
`default_nettype wire

//--- pin_load_model.sv
`timescale 1ns/10ps
`default_nettype none
module pin_load_model (
  input  wire logic       core_clk_i,
  input  wire logic [7:0] zero_pd_i,
  input  wire logic [7:0] zero_pu_i,
  input  wire logic [7:0] one_pd_i,
  input  wire logic [7:0] two_pd_i,
  input  wire logic [7:0] three_pd_i,
  input  wire logic       zero_ext_en_i,
  input  wire logic [7:0] zero_ext_val_i,
  input  wire logic [7:0] one_low_i,
  input  wire logic [7:0] two_low_i,
  input  wire logic [7:0] three_low_i,
  output logic      [7:0] zero_pin_o,
  output logic      [7:0] one_pin_o,
  output logic      [7:0] two_pin_o,
  output logic      [7:0] three_pin_o
);
  // a floating line must never look stable, so it flips every cycle
  logic [7:0] float_pat = 8'h5A;
  always_ff @(posedge core_clk_i) begin
    float_pat <= ~zero_pin_o;
  end
  assign zero_pin_o = ~zero_pd_i
    & (zero_pu_i | (zero_ext_en_i ? zero_ext_val_i : float_pat));
  // quasi ports: pull-up wins unless a load or the driver pulls low
  assign one_pin_o = ~one_pd_i & ~one_low_i;
  assign two_pin_o = ~two_pd_i & ~two_low_i;
  assign three_pin_o = ~three_pd_i & ~three_low_i;
endmodule
`default_nettype wire

//--- quasi_bidir_port_logic_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module quasi_bidir_port_logic_tb_top;
  import qb_port_pkg::*;
  logic       core_clk_i, rstn_i, phase_i, write_latch_i, read_latch_i;
  logic       read_pin_i, bus_rvalid_o, serial_rx_o, p0_en;
  logic       ext_access_i, ext_addr_phase_i, ext_wide_addr_i;
  logic       ext_data_drive_i, serial_tx_i;
  logic       data_write_strobe_n_i, data_read_strobe_n_i;
  logic       ext_interrupt_a_o, ext_interrupt_b_o, timer_a_count_in_o;
  logic       timer_b_count_in_o, timer_c_count_in_o;
  logic       timer_c_capture_trigger_o;
  logic [2:0] state_num_i;
  logic [1:0] port_sel_i;
  logic [7:0] bus_wdata_i, ext_addr_lo_i, ext_addr_hi_i, ext_wdata_i;
  logic [7:0] port_zero_pin_i, port_one_pin_i, port_two_pin_i;
  logic [7:0] port_three_pin_i, bus_rdata_o, ext_rdata_o;
  logic [7:0] port_zero_pulldown_o, port_zero_pullup_o, port_one_pulldown_o;
  logic [7:0] port_two_pulldown_o, port_three_pulldown_o, port_one_strong_o;
  logic [7:0] port_two_strong_o, port_three_strong_o, port_one_keeper_o;
  logic [7:0] port_two_keeper_o, port_three_keeper_o;
  logic [7:0] low_one, low_two, low_three, p0_val, rd;
  int         mismatches, num_checks;

  quasi_bidir_port_logic quasi_bidir_port_logic_inst (.*);
  pin_load_model pin_load_model_inst (
    .core_clk_i     (core_clk_i),
    .zero_pd_i      (port_zero_pulldown_o),
    .zero_pu_i      (port_zero_pullup_o),
    .one_pd_i       (port_one_pulldown_o),
    .two_pd_i       (port_two_pulldown_o),
    .three_pd_i     (port_three_pulldown_o),
    .zero_ext_en_i  (p0_en),
    .zero_ext_val_i (p0_val),
    .one_low_i      (low_one),
    .two_low_i      (low_two),
    .three_low_i    (low_three),
    .zero_pin_o     (port_zero_pin_i),
    .one_pin_o      (port_one_pin_i),
    .two_pin_o      (port_two_pin_i),
    .three_pin_o    (port_three_pin_i)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // cpu timing runs through reset like the real core clock generator
  always @(posedge core_clk_i) begin
    phase_i <= ~phase_i;
    if (phase_i == PHASE_TWO) begin
      state_num_i <= (state_num_i == STATE_SIX) ? STATE_ONE
                     : state_num_i + 3'h1;
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic settle;
    repeat (5) @(posedge core_clk_i);
    #1;
  endtask
  // strobe stands through phase two of the chosen state only
  task automatic wr(input logic [1:0] p, input logic [7:0] d,
                    input logic [2:0] st);
    do begin
      @(posedge core_clk_i);
      #1;
    end while (!(state_num_i == st && phase_i == PHASE_ONE));
    @(posedge core_clk_i);
    write_latch_i <= 1'b1;
    port_sel_i <= p;
    bus_wdata_i <= d;
    @(posedge core_clk_i);
    write_latch_i <= 1'b0;
  endtask
  task automatic rdp(input logic [1:0] p, input logic pin,
                     output logic [7:0] v);
    @(posedge core_clk_i);
    read_latch_i <= ~pin;
    read_pin_i <= pin;
    port_sel_i <= p;
    @(posedge core_clk_i);
    read_latch_i <= 1'b0;
    read_pin_i <= 1'b0;
    #1;
    chk({7'h00, bus_rvalid_o}, 8'h01);
    v = bus_rdata_o;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    for (int p = 0; p < NUM_PORTS; p++) begin
      rdp(2'(p), 1'b0, rd);
      chk(rd, LATCH_RESET);
    end
    chk(port_one_keeper_o & port_two_keeper_o & port_three_keeper_o, ALL_ONES);
  endtask
  task automatic t_rw;
    wr(PORT_ONE, 8'h55, STATE_SIX);
    settle();
    chk(port_one_pulldown_o, 8'hAA);
    @(posedge core_clk_i);
    low_one <= 8'h0F;
    settle();
    rdp(PORT_ONE, 1'b1, rd);
    chk(rd, 8'h50);
    rdp(PORT_ONE, 1'b0, rd);
    chk(rd, 8'h55);
    wr(PORT_ONE, 8'h33, 3'h3);
    settle();
    rdp(PORT_ONE, 1'b0, rd);
    chk(rd, 8'h55);
    low_one <= ALL_ZERO;
  endtask
  task automatic t_strong;
    int n;
    wr(PORT_ONE, ALL_ZERO, STATE_SIX);
    settle();
    rdp(PORT_ONE, 1'b0, rd);
    // only the cpu merges a single bit, the block sees a whole byte
    wr(PORT_ONE, rd | 8'h02, STATE_SIX);
    n = 0;
    repeat (12) begin
      @(posedge core_clk_i);
      #1;
      if (port_one_strong_o === 8'h02) n++;
    end
    chk(8'(n), 8'(BOOST_OSC_PERIODS));
    chk(port_one_keeper_o & 8'h02, 8'h02);
    rdp(PORT_ONE, 1'b0, rd);
    chk(rd, 8'h02);
  endtask
  task automatic t_alt;
    wr(PORT_ONE, ALL_ONES, STATE_SIX);
    wr(PORT_THREE, 8'h3D, STATE_SIX);
    settle();
    chk(port_three_pulldown_o, 8'hC2);
    wr(PORT_THREE, ALL_ONES, STATE_SIX);
    settle();
    chk(port_three_pulldown_o, ALL_ZERO);
    @(posedge core_clk_i);
    serial_tx_i <= 1'b0;
    data_read_strobe_n_i <= 1'b0;
    settle();
    chk(port_three_pulldown_o, 8'h82);
    @(posedge core_clk_i);
    serial_tx_i <= 1'b1;
    data_read_strobe_n_i <= 1'b1;
    data_write_strobe_n_i <= 1'b0;
    settle();
    chk(port_three_pulldown_o, 8'h40);
    @(posedge core_clk_i);
    data_write_strobe_n_i <= 1'b1;
    low_three <= 8'h3D;
    low_one <= 8'h03;
    settle();
    chk({1'b0, timer_c_capture_trigger_o, timer_c_count_in_o,
         timer_b_count_in_o, timer_a_count_in_o, ext_interrupt_b_o,
         ext_interrupt_a_o, serial_rx_o}, ALL_ZERO);
    low_three <= ALL_ZERO;
    low_one <= ALL_ZERO;
    settle();
  endtask
  task automatic t_ext;
    wr(PORT_TWO, 8'h96, STATE_SIX);
    wr(PORT_ZERO, ALL_ZERO, STATE_SIX);
    settle();
    chk(port_zero_pulldown_o, ALL_ONES);
    @(posedge core_clk_i);
    ext_access_i <= 1'b1;
    ext_wide_addr_i <= 1'b1;
    ext_addr_phase_i <= 1'b1;
    ext_addr_hi_i <= 8'hA5;
    ext_addr_lo_i <= 8'h3C;
    settle();
    chk(port_two_pulldown_o, 8'h5A);
    chk(port_two_strong_o | port_three_strong_o, 8'hA5);
    chk(port_zero_pullup_o, 8'h3C);
    chk(port_zero_pulldown_o, 8'hC3);
    @(posedge core_clk_i);
    ext_addr_phase_i <= 1'b0;
    ext_data_drive_i <= 1'b1;
    ext_wdata_i <= 8'h81;
    settle();
    chk(port_zero_pullup_o, 8'h81);
    @(posedge core_clk_i);
    ext_data_drive_i <= 1'b0;
    ext_wide_addr_i <= 1'b0;
    p0_en <= 1'b1;
    p0_val <= 8'h6B;
    settle();
    chk(ext_rdata_o, 8'h6B);
    chk(port_two_pulldown_o, 8'h69);
    chk(port_zero_pullup_o | port_zero_pulldown_o, ALL_ZERO);
    @(posedge core_clk_i);
    ext_access_i <= 1'b0;
    p0_en <= 1'b0;
    settle();
    rdp(PORT_ZERO, 1'b0, rd);
    chk(rd, ALL_ONES);
    rdp(PORT_TWO, 1'b0, rd);
    chk(rd, 8'h96);
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    {rstn_i, write_latch_i, read_latch_i, read_pin_i} = 4'h0;
    {ext_access_i, ext_addr_phase_i, ext_wide_addr_i} = 3'h0;
    {serial_tx_i, data_write_strobe_n_i, data_read_strobe_n_i} = 3'h7;
    {ext_data_drive_i, p0_en, phase_i} = {2'h0, PHASE_ONE};
    state_num_i = STATE_ONE;
    port_sel_i = PORT_ZERO;
    {bus_wdata_i, ext_addr_lo_i, ext_addr_hi_i, ext_wdata_i} = 32'h0;
    {low_one, low_two, low_three, p0_val} = 32'h0;
    mismatches = 0;
    num_checks = 0;
    repeat (6) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_rw();
    t_strong();
    t_alt();
    t_ext();
    @(posedge core_clk_i);
    rstn_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    t_reset();
    end_sim();
  end
  initial begin
    #20000;
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
